/* File: shared/sbit_defs.vh */
// constants for the sixteen-bit interval timer
`ifndef SBIT_DEFS_VH
`define SBIT_DEFS_VH
// register byte offsets
`define SBIT_OFF_CTRL 12'h000
`define SBIT_OFF_PERIOD 12'h004
`define SBIT_OFF_COUNT 12'h008
`define SBIT_OFF_STATUS 12'h00C
// control field positions
`define SBIT_RUN 15
`define SBIT_IDLE_STOP 13
`define SBIT_GATE 6
`define SBIT_PS_HI 5
`define SBIT_PS_LO 4
`define SBIT_SYNC 2
`define SBIT_SRC 1
// writable control bits, everything else reads zero
`define SBIT_CTRL_MASK 16'hA076
`define SBIT_CTRL_RST 16'h0000
`define SBIT_PERIOD_RST 16'hFFFF
`define SBIT_COUNT_RST 16'h0000
// status bit positions
`define SBIT_ST_FLAG 0
`define SBIT_ST_RUNNING 1
`define SBIT_ST_GATE 2
`define SBIT_ST_PIN 3
`define SBIT_ST_MODE_LO 4
`define SBIT_ST_MODE_HI 5
// prescale select codes and terminal counts
`define SBIT_PS_1 2'h0
`define SBIT_PS_8 2'h1
`define SBIT_PS_64 2'h2
`define SBIT_PS_256 2'h3
`define SBIT_TERM_1 8'h00
`define SBIT_TERM_8 8'h07
`define SBIT_TERM_64 8'h3F
`define SBIT_TERM_256 8'hFF
`define SBIT_PRE_RST 8'h00
// mode codes shown in status
`define SBIT_MODE_TIMER 2'h0
`define SBIT_MODE_GATED 2'h1
`define SBIT_MODE_SYNC 2'h2
`define SBIT_MODE_ASYNC 2'h3
`define SBIT_ZERO32 32'h0000_0000
`endif

/* File: hdl/sbit_sync3.v */
// three-stage input synchroniser with second/third agreement
`timescale 1ns/1ps
module sbit_sync3 (
  // clock and reset
  input wire CLK,
  input wire RESETN,
  // raw pin and filtered level
  input wire din,
  output reg dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // first stage feeds only the second
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule

/* File: hdl/sbit_timer.v */
// sixteen-bit interval timer/counter with APB register access
//
// Overview of operation
// - sixteen-bit counter for clock or interval timing
// - count clock may be 32 kHz crystal
// - asynchronous counter mode from external clock
// - sync stage sits after the prescaler
// - timers count instruction clock, counters count pin
// - source, sync and gate choose mode
// - run bit 15 starts and stops counting
// - idle-stop bit 13 halts in idle
// - gate bit 6 only with internal source
// - two-bit prescale: 1, 8, 64, 256
// - sync bit 2 only with external source
// - source bit 1 picks pin rising edge
// - unimplemented bits read zero, reset clears all but period, which resets to FFFF
`timescale 1ns/1ps
`include "sbit_defs.vh"
module sbit_timer (
  // clock and reset
  input wire CLK,
  input wire RESETN,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // external clock pin and gate
  input wire EXT_CLOCK_PIN,
  input wire GATE_PIN,
  // device idle state, same clock domain
  input wire IDLE_MODE,
  // period match flag
  output reg PERIOD_FLAG
);
  reg [15:0] ctrl_q;
  reg [15:0] period_q;
  reg [15:0] count_q;
  reg [15:0] count_d;
  reg [7:0] pre_q;
  reg [7:0] pre_d;
  reg [7:0] pre_term;
  reg pin_prev_q;
  reg sync_tick_q;
  reg flag_d;
  reg [1:0] mode;
  reg [15:0] wr_mask;
  reg [31:0] rd_data;
  reg rd_hit;
  wire pin_lvl;
  wire gate_lvl;
  wire run;
  wire idle_stop;
  wire gate_en;
  wire ext_src;
  wire sync_sel;
  wire [1:0] ps_sel;
  wire setup_ph;
  wire access_ph;
  wire xfer_done;
  wire wr_en;
  wire wr_ctrl;
  wire wr_period;
  wire wr_count;
  wire wr_status;
  wire active;
  wire pin_rise;
  wire src_event;
  wire pre_tick;
  wire cnt_tick;
  wire match;

  // pin and gate come from outside the clock domain
  sbit_sync3 u_pin_sync (
    .CLK(CLK),
    .RESETN(RESETN),
    .din(EXT_CLOCK_PIN),
    .dout(pin_lvl)
  );

  sbit_sync3 u_gate_sync (
    .CLK(CLK),
    .RESETN(RESETN),
    .din(GATE_PIN),
    .dout(gate_lvl)
  );

  assign run = ctrl_q[`SBIT_RUN];
  assign idle_stop = ctrl_q[`SBIT_IDLE_STOP];
  assign gate_en = ctrl_q[`SBIT_GATE];
  assign ext_src = ctrl_q[`SBIT_SRC];
  assign sync_sel = ctrl_q[`SBIT_SYNC];
  assign ps_sel = ctrl_q[`SBIT_PS_HI:`SBIT_PS_LO];

  // apb phases; one wait state, write lands on the pready edge
  assign setup_ph = PSEL & ~PENABLE;
  assign access_ph = PSEL & PENABLE;
  assign xfer_done = access_ph & PREADY;
  assign wr_en = xfer_done & PWRITE;
  assign wr_ctrl = wr_en & (PADDR == `SBIT_OFF_CTRL);
  assign wr_period = wr_en & (PADDR == `SBIT_OFF_PERIOD);
  assign wr_count = wr_en & (PADDR == `SBIT_OFF_COUNT);
  assign wr_status = wr_en & (PADDR == `SBIT_OFF_STATUS);

  // byte lanes 0 and 1 hold the sixteen-bit registers
  always @* begin
    wr_mask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
  end

  always @* begin
    if (!ext_src) begin
      if (gate_en) begin
        mode = `SBIT_MODE_GATED;
      end else begin
        mode = `SBIT_MODE_TIMER;
      end
    end else if (sync_sel) begin
      mode = `SBIT_MODE_SYNC;
    end else begin
      mode = `SBIT_MODE_ASYNC;
    end
  end

  // only implemented bits stored, reset zero
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= `SBIT_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= ((PWDATA[15:0] & wr_mask) | (ctrl_q & ~wr_mask)) & `SBIT_CTRL_MASK;
    end
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      period_q <= `SBIT_PERIOD_RST;
    end else if (wr_period) begin
      period_q <= (PWDATA[15:0] & wr_mask) | (period_q & ~wr_mask);
    end
  end

  assign active = run & ~(idle_stop & IDLE_MODE);

  // external pin counted on rising edge
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_lvl;
    end
  end

  assign pin_rise = pin_lvl & ~pin_prev_q;

  // slow crystal on the pin counts as external source
  assign src_event = ext_src ? pin_rise : (~gate_en | gate_lvl);

  always @* begin
    case (ps_sel)
      `SBIT_PS_1: pre_term = `SBIT_TERM_1;
      `SBIT_PS_8: pre_term = `SBIT_TERM_8;
      `SBIT_PS_64: pre_term = `SBIT_TERM_64;
      `SBIT_PS_256: pre_term = `SBIT_TERM_256;
      default: pre_term = `SBIT_TERM_1;
    endcase
  end

  assign pre_tick = active & src_event & (pre_q == pre_term);

  // prescaler cleared on control write so a new ratio starts clean
  always @* begin
    pre_d = pre_q;
    if (wr_ctrl || !run) begin
      pre_d = `SBIT_PRE_RST;
    end else if (active && src_event) begin
      if (pre_q == pre_term) begin
        pre_d = `SBIT_PRE_RST;
      end else begin
        pre_d = pre_q + 8'h01;
      end
    end
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pre_q <= `SBIT_PRE_RST;
    end else begin
      pre_q <= pre_d;
    end
  end

  // sync stage placed after the prescaler
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync_tick_q <= 1'b0;
    end else begin
      sync_tick_q <= pre_tick & ext_src & sync_sel & run;
    end
  end

  // sync select ignored with internal source
  // async counter bypasses the post-prescale stage
  // gate ignored when source is external
  assign cnt_tick = ext_src ? (sync_sel ? (sync_tick_q & active) : pre_tick) : pre_tick;

  // wrap to zero after period match
  assign match = (count_q == period_q);

  always @* begin
    count_d = count_q;
    if (wr_count) begin
      count_d = (PWDATA[15:0] & wr_mask) | (count_q & ~wr_mask);
    end else if (cnt_tick) begin
      if (match) begin
        count_d = `SBIT_COUNT_RST;
      end else begin
        count_d = count_q + 16'h0001;
      end
    end
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      count_q <= `SBIT_COUNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  // flag set on match, set beats clear
  always @* begin
    flag_d = PERIOD_FLAG;
    if (wr_status && PSTRB[0] && PWDATA[`SBIT_ST_FLAG]) begin
      flag_d = 1'b0;
    end
    if (cnt_tick && match && !wr_count) begin
      flag_d = 1'b1;
    end
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PERIOD_FLAG <= 1'b0;
    end else begin
      PERIOD_FLAG <= flag_d;
    end
  end

  // read mux; unmapped addresses answer with slave error
  always @* begin
    rd_data = `SBIT_ZERO32;
    rd_hit = 1'b1;
    case (PADDR)
      `SBIT_OFF_CTRL: begin
        rd_data[15:0] = ctrl_q & `SBIT_CTRL_MASK;
      end
      `SBIT_OFF_PERIOD: begin
        rd_data[15:0] = period_q;
      end
      `SBIT_OFF_COUNT: begin
        rd_data[15:0] = count_q;
      end
      `SBIT_OFF_STATUS: begin
        rd_data[`SBIT_ST_FLAG] = PERIOD_FLAG;
        rd_data[`SBIT_ST_RUNNING] = active;
        rd_data[`SBIT_ST_GATE] = gate_lvl;
        rd_data[`SBIT_ST_PIN] = pin_lvl;
        rd_data[`SBIT_ST_MODE_HI:`SBIT_ST_MODE_LO] = mode;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // pready rises one cycle into the access phase, for one cycle
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PRDATA <= `SBIT_ZERO32;
      PSLVERR <= 1'b0;
    end else begin
      if (access_ph && !PREADY) begin
        PREADY <= 1'b1;
        PSLVERR <= ~rd_hit;
        if (!PWRITE) begin
          PRDATA <= rd_data;
        end else begin
          PRDATA <= `SBIT_ZERO32;
        end
      end else begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        if (setup_ph) begin
          PRDATA <= `SBIT_ZERO32;
        end
      end
    end
  end
endmodule

/* File: tb/sbit_chk.sv */
// port assertions for the interval timer
`timescale 1ns/1ps
module sbit_chk (
  // clock and reset
  input wire CLK,
  input wire RESETN,
  // apb
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  // match flag
  input wire PERIOD_FLAG
);
  wire rd = PREADY && !PWRITE;
  wire clr = PREADY && PWRITE && PADDR == 12'h00C;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_acc;
    PSEL && !PENABLE ##1 PSEL && PENABLE;
  endsequence
  property p_rdy; s_acc |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_pls; PREADY |=> !PREADY; endproperty
  a_pls: assert property (p_pls) else $error("ready held");
  // misaligned addresses below the status word are unmapped too
  property p_err; PSLVERR |-> PREADY && (PADDR > 12'h00C || PADDR[1:0] != 2'h0); endproperty
  a_err: assert property (p_err) else $error("bad slverr");
  property p_map; PREADY && PADDR <= 12'h00C && PADDR[1:0] == 2'h0 |-> !PSLVERR; endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  property p_ctl; rd && PADDR == 12'h000 |-> (PRDATA & ~32'h0000_A076) == 0; endproperty
  a_ctl: assert property (p_ctl) else $error("ctrl spare bits");
  property p_hi; rd |-> PRDATA[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper half set");
  property p_st; rd && PADDR == 12'h00C |-> PRDATA[31:6] == 0; endproperty
  a_st: assert property (p_st) else $error("status spare bits");
  property p_stk; PERIOD_FLAG && !clr |=> PERIOD_FLAG; endproperty
  a_stk: assert property (p_stk) else $error("flag lost");
endmodule
bind sbit_timer sbit_chk u_chk (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
  .PREADY, .PSLVERR, .PERIOD_FLAG);

/* File: tb/sbit_ext_src.sv */
// behavioural external count clock source
`timescale 1ns/1ps
module sbit_ext_src (
  // burst request
  input wire [7:0] n,
  input wire go,
  // pin and burst status
  output reg pin,
  output reg busy
);
  initial begin
    pin = 1'h0;
    busy = 1'h0;
  end
  // rising edges counted
  // both levels over three clocks so the sync sees them
  // odd fractions keep pin edges off the clock edges for a whole burst
  always @(posedge go) begin
    busy = 1'h1;
    repeat (n) begin
      #37.5 pin = 1'h1;
      #41.2 pin = 1'h0;
    end
    busy = 1'h0;
  end
endmodule

/* File: tb/sbit_timer_tb_top.sv */
// self-checking bench for the interval timer
`timescale 1ns/1ps
module sbit_timer_tb_top;
  localparam [31:0] Z = 32'h0000_0000;
  reg clk = 1'h0;
  reg rst_n = 1'h0;
  reg psel = 1'h0;
  reg pen = 1'h0;
  reg pwr = 1'h0;
  reg [11:0] pa = 12'h000;
  reg [31:0] pwd = Z;
  reg gate = 1'h0;
  reg idle = 1'h0;
  reg go = 1'h0;
  reg [7:0] np = 8'h00;
  reg [31:0] rdv;
  reg errv;
  wire [31:0] prd;
  wire rdy, err, pin, busy, flag;
  integer errors = 0;
  integer checks_done = 0;
  integer i;
  always #5 clk = ~clk;
  sbit_timer uut (.CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PSTRB(4'h3), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
    .EXT_CLOCK_PIN(pin), .GATE_PIN(gate), .IDLE_MODE(idle), .PERIOD_FLAG(flag));
  sbit_ext_src src (.n(np), .go(go), .pin(pin), .busy(busy));
  task finish_test;
    begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] lo, input [31:0] hi, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if ((got >= lo && got <= hi) !== 1'h1) begin
        errors = errors + 1;
        $display("FAIL %s exp %0h got %0h", nm, lo, got);
      end
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      while (rdy !== 1'h1) @(posedge clk);
      rdv = prd;
      errv = err;
      psel <= 1'h0;
      pen <= 1'h0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task rd(input [11:0] a);
    xfer(1'h0, a, Z);
  endtask
  task t_regs;
    begin
      chk("flag", 0, 0, flag);
      rd(12'h000);
      chk("ctrl", 0, 0, rdv);
      rd(12'h004);
      chk("period", 32'h0000_FFFF, 32'h0000_FFFF, rdv);
      wr(12'h000, 32'h0000_FFFF);
      rd(12'h000);
      chk("ctrl", 32'h0000_A076, 32'h0000_A076, rdv);
      wr(12'h000, Z);
      rd(12'h010);
      chk("slverr", 1, 1, errv);
      chk("unmapped", 0, 0, rdv);
      rd(12'h002);
      chk("misaligned", 1, 1, errv);
    end
  endtask
  // slack of six covers the two control writes
  task t_count(input [15:0] c, input [31:0] lo, input [1:0] m);
    reg [31:0] v;
    begin
      wr(12'h008, Z);
      wr(12'h000, {16'h0000, c | 16'h8000});
      repeat (512) @(posedge clk);
      wr(12'h000, {16'h0000, c});
      rd(12'h008);
      v = rdv;
      chk("count", lo, lo + 6, v);
      repeat (20) @(posedge clk);
      rd(12'h008);
      chk("held", v, v, rdv);
      rd(12'h00C);
      chk("mode", m, m, rdv[5:4]);
    end
  endtask
  task t_ext(input [15:0] c, input [7:0] n, input [31:0] e, input [1:0] m);
    begin
      wr(12'h008, Z);
      wr(12'h000, {16'h0000, c | 16'h8000});
      np <= n;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      while (busy === 1'h1) @(posedge clk);
      repeat (10) @(posedge clk);
      rd(12'h008);
      chk("ext", e, e, rdv);
      rd(12'h00C);
      chk("mode", m, m, rdv[5:4]);
      wr(12'h000, {16'h0000, c});
    end
  endtask
  task t_wrap;
    begin
      wr(12'h008, Z);
      wr(12'h004, 32'h0000_0004);
      wr(12'h000, 32'h0000_8000);
      repeat (30) @(posedge clk);
      wr(12'h000, Z);
      rd(12'h008);
      chk("wrap", 0, 4, rdv);
      chk("flag", 1, 1, flag);
      wr(12'h00C, 32'h0000_0001);
      @(posedge clk);
      chk("flag", 0, 0, flag);
      wr(12'h004, 32'h0000_FFFF);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_regs;
    for (i = 0; i < 4; i = i + 1) begin
      t_count({10'h000, i[1:0], 4'h0}, i == 3 ? 2 : 512 >> (3 * i), 0);
    end
    idle <= 1'h1;
    t_count(16'h2000, 0, 0);
    t_count(16'h0000, 512, 0);
    idle <= 1'h0;
    t_count(16'h0040, 0, 1);
    gate <= 1'h1;
    t_count(16'h0040, 512, 1);
    gate <= 1'h0;
    t_ext(16'h0002, 20, 20, 3);
    t_ext(16'h0006, 20, 20, 2);
    t_ext(16'h0016, 16, 2, 2);
    t_ext(16'h0042, 20, 20, 3);
    t_wrap;
    finish_test;
  end
  initial begin
    #500000;
    errors = errors + 1;
    finish_test;
  end
endmodule
